// File: dcs_ctrl.sv
// DC output state control, analog interface signalling and APB registers.
// Assumes mains, switch and standby pins are asynchronous, alarms are
// synchronous flags from protection logic, and storage keeps nv_* values.
`timescale 1ns/10ps
module dcs_ctrl #(
  parameter int FAN_CYC = dcs_pkg::FAN_STOP_CYC,
  parameter int OFF_CYC = dcs_pkg::POWER_OFF_CYC
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        mains_ok,
  input  wire logic        power_switch_off,
  input  wire logic        remote_standby_input,
  input  wire logic        overtemperature_alarm,
  input  wire logic        overvoltage_alarm,
  input  wire logic        overcurrent_alarm,
  input  wire logic        overpower_alarm,
  input  wire logic        constant_voltage_regulation,
  input  wire logic        nv_restore_on,
  output logic             dc_on,
  output logic             fan_on,
  output logic             power_hold,
  output logic             nv_store,
  output logic             nv_on,
  output logic [15:0]      nv_setval,
  output logic             alarm_pin1,
  output logic             alarm_pin2,
  output logic             status_pin,
  output logic             ref_10v,
  output logic             local_only,
  output logic             irq
);

  // ==========================================================
  // Pin synchronisers. Mains resets as present, so release is quiet.
  logic [2:0] pin_raw, sync_a, sync_b;
  assign pin_raw = {remote_standby_input, power_switch_off, mains_ok};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge clk) begin
        if (srst) begin
          sync_a[gi] <= 1'(gi == 0);
          sync_b[gi] <= 1'(gi == 0);
        end else begin
          sync_a[gi] <= pin_raw[gi];
          sync_b[gi] <= sync_a[gi];
        end
      end
    end
  endgenerate

  logic mains_s, sw_s, sb_act, prot, pf_alarm;
  assign mains_s  = sync_b[0];
  assign sw_s     = sync_b[1];
  dcs_pkg::dcs_cfg_t cfg;
  assign sb_act   = sync_b[2] ^ cfg.sb_invert;
  assign prot     = overvoltage_alarm | overcurrent_alarm | overpower_alarm;
  assign pf_alarm = !mains_s | sw_s;

  // ==========================================================
  // Edge detection.
  logic       ot_q, pf_q, sb_q, sw_q;
  logic [2:0] prot_q;
  always_ff @(posedge clk) begin
    if (srst) begin
      ot_q   <= 1'b0;
      pf_q   <= 1'b0;
      sb_q   <= 1'b0;
      sw_q   <= 1'b0;
      prot_q <= 3'h0;
    end else begin
      ot_q   <= overtemperature_alarm;
      pf_q   <= pf_alarm;
      sb_q   <= sb_act;
      sw_q   <= sw_s;
      prot_q <= {overpower_alarm, overcurrent_alarm, overvoltage_alarm};
    end
  end

  logic ot_rise, ot_fall, pf_rise, pf_fall;
  logic sb_rise, sb_fall, sw_rise;
  assign ot_rise = overtemperature_alarm & !ot_q;
  assign ot_fall = !overtemperature_alarm & ot_q;
  assign pf_rise = pf_alarm & !pf_q;
  assign pf_fall = !pf_alarm & pf_q;
  assign sb_rise = sb_act & !sb_q;
  assign sb_fall = !sb_act & sb_q;
  assign sw_rise = sw_s & !sw_q;

  // ==========================================================
  // APB access decode.
  logic acc, wr, hit;
  assign acc = psel & penable & pready;
  assign wr  = acc & pwrite;
  assign hit = paddr == dcs_pkg::OFS_CFG || paddr == dcs_pkg::OFS_CMD
            || paddr == dcs_pkg::OFS_STATUS || paddr == dcs_pkg::OFS_IRQ
            || paddr == dcs_pkg::OFS_MASK || paddr == dcs_pkg::OFS_SETVAL;

  logic remote_active, remote_ok, cmd_wr, cmd_src_ok;
  logic cmd_on, cmd_off, leave;
  assign remote_ok  = remote_active & cfg.remote_allow;
  assign cmd_wr     = wr & paddr == dcs_pkg::OFS_CMD;
  assign cmd_src_ok = pwdata[dcs_pkg::CMD_REMOTE] ? remote_ok
                                                  : !remote_active;
  assign cmd_on     = cmd_wr & cmd_src_ok & pwdata[dcs_pkg::CMD_ON];
  assign cmd_off    = cmd_wr & cmd_src_ok & pwdata[dcs_pkg::CMD_OFF];
  assign leave      = cmd_wr & remote_active & pwdata[dcs_pkg::CMD_REM_EX];

  // ==========================================================
  // Configuration, locked while the output is on.
  logic cfg_wr, cfg_valid, cfg_rej;
  assign cfg_wr    = wr & paddr == dcs_pkg::OFS_CFG;
  assign cfg_valid = pwdata[5:4] != 2'h0 && pwdata[8:6] != 3'h0;
  assign cfg_rej   = cfg_wr & (dc_on | !cfg_valid);

  always_ff @(posedge clk) begin
    if (srst) begin
      cfg <= dcs_pkg::CFG_RST;
    end else if (cfg_wr && !cfg_rej) begin
      cfg <= pwdata[dcs_pkg::CFG_W-1:0];
    end
  end

  logic [15:0] setval;
  always_ff @(posedge clk) begin
    if (srst) begin
      setval <= 16'h0000;
    end else if (wr && paddr == dcs_pkg::OFS_SETVAL) begin
      setval <= pwdata[15:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      remote_active <= 1'b0;
    end else if (!cfg.remote_allow || leave) begin
      remote_active <= 1'b0;
    end else if (cmd_wr && pwdata[dcs_pkg::CMD_REM_IN]) begin
      remote_active <= 1'b1;
    end
  end

  // ==========================================================
  // Restore memories.
  logic pu_pend, ot_resume, pf_resume, sb_held, sb_use;
  assign sb_use = cfg.remote_allow;

  always_ff @(posedge clk) begin
    if (srst) begin
      pu_pend   <= 1'b1;
      ot_resume <= 1'b0;
      pf_resume <= 1'b0;
      sb_held   <= 1'b0;
    end else begin
      pu_pend <= 1'b0;
      if (ot_rise) begin
        ot_resume <= cfg.ot_auto & dc_on;
      end else if (ot_fall) begin
        ot_resume <= 1'b0;
      end
      if (pf_rise) begin
        pf_resume <= cfg.pf_auto & dc_on & !sw_s;
      end else if (pf_fall) begin
        pf_resume <= 1'b0;
      end
      if (sb_rise && sb_use) begin
        sb_held <= cfg.sb_auto & dc_on;
      end else if (sb_fall) begin
        sb_held <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Output state, highest priority first.
  logic next_dc;
  always_comb begin
    next_dc = dc_on;
    if (sw_s || pf_alarm || overtemperature_alarm || prot) begin
      next_dc = 1'b0;
    end else if (pu_pend) begin
      next_dc = cfg.pon_restore & nv_restore_on;
    end else if (pf_fall && pf_resume) begin
      next_dc = 1'b1;
    end else if (ot_fall && ot_resume) begin
      next_dc = 1'b1;
    end else if (sb_rise && sb_use) begin
      next_dc = 1'b0;
    end else if (sb_fall && sb_use && sb_held) begin
      next_dc = 1'b1;
    end else if (leave) begin
      next_dc = cfg.rem_keep & dc_on;
    end else if (cmd_off) begin
      next_dc = 1'b0;
    end else if (cmd_on && !(sb_act && sb_use)) begin
      next_dc = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      dc_on <= 1'b0;
    end else begin
      dc_on <= next_dc;
    end
  end

  // ==========================================================
  // Switch-off sequence. The snapshot is taken before the output
  // drops, so storage sees the state the user left.
  dcs_pkg::dcs_pd_t pd;
  logic [31:0] pd_cnt;
  always_ff @(posedge clk) begin
    if (srst) begin
      pd     <= dcs_pkg::DCS_RUN;
      pd_cnt <= 32'h0;
    end else begin
      unique case (pd)
        dcs_pkg::DCS_RUN: begin
          if (sw_rise) begin
            pd     <= dcs_pkg::DCS_FAN;
            pd_cnt <= 32'(FAN_CYC - 1);
          end
        end
        dcs_pkg::DCS_FAN: begin
          if (pd_cnt == 32'h0) begin
            pd     <= dcs_pkg::DCS_HOLD;
            pd_cnt <= 32'(OFF_CYC - 1);
          end else begin
            pd_cnt <= pd_cnt - 32'h1;
          end
        end
        dcs_pkg::DCS_HOLD: begin
          if (pd_cnt == 32'h0) begin
            pd <= dcs_pkg::DCS_DOWN;
          end else begin
            pd_cnt <= pd_cnt - 32'h1;
          end
        end
        dcs_pkg::DCS_DOWN: pd <= dcs_pkg::DCS_DOWN;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      fan_on     <= 1'b1;
      power_hold <= 1'b1;
    end else begin
      fan_on     <= pd == dcs_pkg::DCS_RUN || pd == dcs_pkg::DCS_FAN;
      power_hold <= pd != dcs_pkg::DCS_DOWN;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      nv_store  <= 1'b0;
      nv_on     <= 1'b0;
      nv_setval <= 16'h0000;
    end else begin
      nv_store <= sw_rise;
      if (sw_rise) begin
        nv_on     <= dc_on;
        nv_setval <= setval;
      end
    end
  end

  // ==========================================================
  // Analog interface outputs.
  always_ff @(posedge clk) begin
    if (srst) begin
      alarm_pin1 <= 1'b0;
      alarm_pin2 <= 1'b0;
      status_pin <= 1'b0;
      ref_10v    <= 1'b0;
      local_only <= 1'b1;
    end else begin
      alarm_pin1 <= (cfg.pin6_en[0] & overtemperature_alarm)
                  | (cfg.pin6_en[1] & pf_alarm);
      alarm_pin2 <= |(cfg.pin14_en & prot_q);
      status_pin <= cfg.pin15_dc ? dc_on
                  : constant_voltage_regulation;
      ref_10v    <= cfg.range_10v;
      local_only <= !cfg.remote_allow;
    end
  end

  // ==========================================================
  // Interrupts: sticky events, set wins over a write-one clear.
  logic [dcs_pkg::IRQ_W-1:0] irq_stat, irq_mask, irq_ev, irq_clr;
  assign irq_ev = {cfg_rej, next_dc ^ dc_on, {overpower_alarm,
                   overcurrent_alarm, overvoltage_alarm} & ~prot_q,
                   pf_rise, ot_rise};
  assign irq_clr = (wr && paddr == dcs_pkg::OFS_IRQ)
                 ? pwdata[dcs_pkg::IRQ_W-1:0] : '0;

  always_ff @(posedge clk) begin
    if (srst) begin
      irq_stat <= '0;
      irq_mask <= '0;
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_ev;
      if (wr && paddr == dcs_pkg::OFS_MASK) begin
        irq_mask <= pwdata[dcs_pkg::IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat & irq_mask);
    end
  end

  // ==========================================================
  // APB answer: one wait state, registered data.
  logic [31:0] next_rd;
  always_comb begin
    next_rd = 32'h0;
    unique case (paddr)
      dcs_pkg::OFS_CFG:    next_rd = 32'(cfg);
      dcs_pkg::OFS_STATUS: next_rd = {25'h0, pd, local_only,
                           remote_active, overtemperature_alarm,
                           pf_alarm, dc_on};
      dcs_pkg::OFS_IRQ:    next_rd = 32'(irq_stat);
      dcs_pkg::OFS_MASK:   next_rd = 32'(irq_mask);
      dcs_pkg::OFS_SETVAL: next_rd = {16'h0, setval};
      default:             next_rd = 32'h0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & penable & !pready;
      prdata  <= (psel && !pwrite) ? next_rd : 32'h0;
      pslverr <= psel & penable & !pready & !hit;
    end
  end

  // ==========================================================
  // Checks.
  sequence s_switch_off;
    $rose(sw_s) ##1 nv_store;
  endsequence

  AST_NV_SNAPSHOT: assert property (@(posedge clk) disable iff (srst)
    $rose(sw_s) |=> nv_store && nv_on == $past(dc_on))
    else $error("snapshot missing at switch-off");
  AST_SWITCH_OFF: assert property (@(posedge clk) disable iff (srst)
    s_switch_off |-> !dc_on ##1 !dc_on)
    else $error("output stayed on after switch-off");
  AST_CFG_LOCK: assert property (@(posedge clk) disable iff (srst)
    dc_on && cfg_wr |=> $stable(cfg))
    else $error("configuration changed while output on");
  AST_LOCAL: assert property (@(posedge clk) disable iff (srst)
    !cfg.remote_allow |=> !remote_active && local_only)
    else $error("remote kept without permission");
  AST_RANGE: assert property (@(posedge clk) disable iff (srst)
    ##1 ref_10v == $past(cfg.range_10v))
    else $error("reference range mismatch");
  AST_SB_OFFONLY: assert property (@(posedge clk) disable iff (srst)
    sb_fall && !cfg.sb_auto && !cmd_wr |=> !$rose(dc_on))
    else $error("standby turned output on in off-only mode");
  AST_PIN1: assert property (@(posedge clk) disable iff (srst)
    cfg.pin6_en == 2'h1 ##1 1'b1 |-> alarm_pin1 == $past(
      overtemperature_alarm))
    else $error("alarm pin one wrong");
  AST_PIN15: assert property (@(posedge clk) disable iff (srst)
    !cfg.pin15_dc |=> status_pin == $past(constant_voltage_regulation))
    else $error("status pin wrong");
  AST_OT_OFF: assert property (@(posedge clk) disable iff (srst)
    $rose(overtemperature_alarm) |=> !dc_on)
    else $error("output on during overtemperature");
  AST_PON_OFF: assert property (@(posedge clk)
    $fell(srst) && !cfg.pon_restore |=> !dc_on)
    else $error("output on after power-up with off setting");

endmodule : dcs_ctrl

// File: dcs_far_end.sv
// Far-side model: analog interface pins, mains and switch, storage.
// Assumes the bench sets drive[] after a rising edge of clk.
`timescale 1ns/10ps
module dcs_far_end (
  input  wire logic       clk,
  input  wire logic [7:0] drive,
  input  wire logic       nv_store,
  input  wire logic       nv_on,
  output logic            mains_ok,
  output logic            power_switch_off,
  output logic            remote_standby_input,
  output logic            overtemperature_alarm,
  output logic            overvoltage_alarm,
  output logic            overcurrent_alarm,
  output logic            overpower_alarm,
  output logic            constant_voltage_regulation,
  output logic            nv_restore_on
);
  // ==========================================================
  // Pins
  // The pins pass through a register so that they move only on edges.
  always_ff @(posedge clk) begin
    mains_ok                    <= drive[0];
    power_switch_off            <= drive[1];
    remote_standby_input        <= drive[2];
    overtemperature_alarm       <= drive[3];
    overvoltage_alarm           <= drive[4];
    overcurrent_alarm           <= drive[5];
    overpower_alarm             <= drive[6];
    constant_voltage_regulation <= drive[7];
  end

  // ==========================================================
  // Storage
  // The saved state survives resets of the block, as real storage does.
  logic saved_on = 1'b0;
  assign nv_restore_on = saved_on;
  always_ff @(posedge clk) begin
    if (nv_store) begin
      saved_on <= nv_on;
    end
  end
endmodule : dcs_far_end

// File: dcs_pkg.sv
// Constants and types for the DC output state and alarm signalling block.
// Assumes one 250 MHz clock and an APB master for software access.
// Operation
// - Save output state and set value at switch-off
// - Switch-off: output off, fail alarm, fans, power-down
// - Accept configuration only while output is off
// - No remote permission: reject remote, show local
// - Range selects 5 V or 10 V scaling
// - Standby input polarity normal or inverted
// - Off-only standby never turns output on
// - Automatic standby restores output switched on elsewhere
// - Pin one: overtemperature and power fail, enables
// - Pin two: overvoltage, overcurrent, overpower enables
// - Status pin: regulation mode or output state
// - After overtemperature: stay off or restore
// - Power-up: output off or restore saved (code: always off, pon_restore is 0 from CFG_RST in the power-up cycle)
// - After power fail: stay off or resume
// - Leaving remote sets output by setting
package dcs_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] OFS_CFG    = 8'h00;
  localparam logic [7:0] OFS_CMD    = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_IRQ    = 8'h0c;
  localparam logic [7:0] OFS_MASK   = 8'h10;
  localparam logic [7:0] OFS_SETVAL = 8'h14;

  // ==========================================================
  // Command bits
  localparam int CMD_ON     = 0;
  localparam int CMD_OFF    = 1;
  localparam int CMD_REM_IN = 2;
  localparam int CMD_REM_EX = 3;
  localparam int CMD_REMOTE = 4;

  // ==========================================================
  // Interrupt bits
  localparam int IRQ_W     = 7;
  localparam int IRQ_OT    = 0;
  localparam int IRQ_PF    = 1;
  localparam int IRQ_OVP   = 2;
  localparam int IRQ_OCP   = 3;
  localparam int IRQ_OPP   = 4;
  localparam int IRQ_DC    = 5;
  localparam int IRQ_REJ   = 6;

  // ==========================================================
  // Configuration word, bit 0 is remote_allow.
  typedef struct packed {
    logic       rem_keep;
    logic       pf_auto;
    logic       pon_restore;
    logic       ot_auto;
    logic       pin15_dc;
    logic [2:0] pin14_en;
    logic [1:0] pin6_en;
    logic       sb_auto;
    logic       sb_invert;
    logic       range_10v;
    logic       remote_allow;
  } dcs_cfg_t;

  localparam int CFG_W = 14;
  localparam logic [13:0] CFG_RST = 14'h0071;

  // ==========================================================
  // Timing
  localparam int CLK_MHZ     = 250;
  localparam int FAN_STOP_US = 100000;
  localparam int POWER_OFF_US = 3000000;
  localparam int FAN_STOP_CYC  = FAN_STOP_US * CLK_MHZ;
  localparam int POWER_OFF_CYC = POWER_OFF_US * CLK_MHZ;

  typedef enum logic [1:0] {
    DCS_RUN, DCS_FAN, DCS_HOLD, DCS_DOWN
  } dcs_pd_t;

endpackage : dcs_pkg

// File: tb_top.sv
// Self-checking bench for dcs_ctrl driven over APB and analog pins.
// Assumes the far-side model in dcs_far_end and short power-down counts.
`timescale 1ns/10ps
module tb_top;
  // ==========================================================
  // Signals
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        pready, pslverr, dc_on, fan_on, power_hold, nv_store;
  logic        nv_on, alarm_pin1, alarm_pin2, status_pin, ref_10v;
  logic        local_only, irq, mains_ok, power_switch_off;
  logic        remote_standby_input, overtemperature_alarm;
  logic        overvoltage_alarm, overcurrent_alarm, overpower_alarm;
  logic        constant_voltage_regulation, nv_restore_on;
  logic [31:0] prdata, rdata;
  logic [15:0] nv_setval;
  logic [7:0]  pins = 8'h01;
  logic        last_err;
  int          err_count = 0;
  int          checks_done = 0;
  int          k, a;

  localparam logic [31:0] BASE  = 32'h0000_0071;
  localparam logic [31:0] C_ON  = 32'h1 << dcs_pkg::CMD_ON;
  localparam logic [31:0] C_IN  = 32'h1 << dcs_pkg::CMD_REM_IN;
  localparam logic [31:0] C_EX  = 32'h1 << dcs_pkg::CMD_REM_EX;
  localparam logic [31:0] C_REM = 32'h1 << dcs_pkg::CMD_REMOTE;

  `define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
    err_count++; $display("mismatch %s exp %h seen %h", nm, e, g); end end

  always #2 clk = ~clk;

  dcs_ctrl #(.FAN_CYC(20), .OFF_CYC(40)) dut (.*);
  dcs_far_end far (.*, .drive(pins));

  // ==========================================================
  // Tasks
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // Holds the request until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [7:0] ad,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= ad;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdata    = prdata;
    last_err = pslverr;
    if (n >= 50) begin
      err_count++;
      $display("mismatch pready exp 1 seen %b", pready);
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d);
    tick(3);
  endtask : wr

  task automatic rd(input logic [7:0] ad);
    apb(1'b0, ad, 32'h0);
  endtask : rd

  // Pins cross a synchroniser, so allow a few edges to settle.
  task automatic pin(input int idx, input logic v);
    @(posedge clk);
    pins[idx] <= v;
    tick(8);
  endtask : pin

  // Output on, event on pin idx, event gone; auto bit decides the end.
  task automatic recover(input int cb, input int idx, input logic act);
    for (int au = 0; au < 2; au++) begin
      wr(dcs_pkg::OFS_CFG, BASE | (32'(au) << cb));
      wr(dcs_pkg::OFS_CMD, C_ON);
      `CHK("dc_on before event", 1'b1, dc_on)
      pin(idx, act);
      `CHK("dc_on during event", 1'b0, dc_on)
      pin(idx, ~act);
      `CHK("dc_on after event", 1'(au), dc_on)
      wr(dcs_pkg::OFS_CMD, 32'h1 << dcs_pkg::CMD_OFF);
    end
  endtask : recover

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish

  // ==========================================================
  // Watchdog
  initial begin
    tick(20000);
    err_count++;
    tally_and_finish;
  end

  // ==========================================================
  // Tests
  initial begin
    tick(4);
    srst <= 1'b0;
    tick(3);
    `CHK("dc_on at power-up", 1'b0, dc_on)
    rd(dcs_pkg::OFS_CFG);
    `CHK("cfg reset", 32'h0000_0071, rdata)
    rd(dcs_pkg::OFS_MASK);
    `CHK("mask reset", 32'h0, rdata)
    rd(8'h3c);
    `CHK("unmapped pslverr", 1'b1, last_err)
    pin(7, 1'b1);
    `CHK("status pin cv", 1'b1, status_pin)
    // Rejected write while on raises the masked event bit.
    wr(dcs_pkg::OFS_CMD, C_ON);
    wr(dcs_pkg::OFS_CFG, BASE | 32'h2);
    rd(dcs_pkg::OFS_CFG);
    `CHK("cfg kept while on", BASE, rdata)
    `CHK("irq masked", 1'b0, irq)
    wr(dcs_pkg::OFS_MASK, 32'h40);
    `CHK("irq on reject", 1'b1, irq)
    wr(dcs_pkg::OFS_IRQ, 32'h40);
    `CHK("irq cleared", 1'b0, irq)
    wr(dcs_pkg::OFS_MASK, 32'h0);
    wr(dcs_pkg::OFS_CMD, 32'h1 << dcs_pkg::CMD_OFF);
    // Range and status pin selection.
    wr(dcs_pkg::OFS_CFG, BASE | 32'h202);
    `CHK("ref 10v", 1'b1, ref_10v)
    `CHK("status pin dc", 1'b0, status_pin)
    wr(dcs_pkg::OFS_CMD, C_ON);
    `CHK("status pin dc on", 1'b1, status_pin)
    wr(dcs_pkg::OFS_CMD, 32'h1 << dcs_pkg::CMD_OFF);
    // Every nonzero enable combination of both alarm pins.
    for (k = 1; k < 8; k++) begin
      wr(dcs_pkg::OFS_CFG,
         32'h1 | (32'(k) << 6) | (32'((k - 1) % 3 + 1) << 4));
      for (a = 0; a < 3; a++) begin
        pin(4 + a, 1'b1);
        `CHK("alarm pin2", k[a], alarm_pin2)
        pin(4 + a, 1'b0);
      end
      pin(3, 1'b1);
      `CHK("alarm pin1 ot", 1'(((k - 1) % 3 + 1) & 1), alarm_pin1)
      pin(3, 1'b0);
      pin(0, 1'b0);
      `CHK("alarm pin1 pf", 1'(((k - 1) % 3 + 1) >> 1), alarm_pin1)
      pin(0, 1'b1);
    end
    // Standby with off-only action, then automatic in both polarities.
    wr(dcs_pkg::OFS_CFG, BASE);
    wr(dcs_pkg::OFS_CMD, C_ON);
    pin(2, 1'b1);
    `CHK("standby off", 1'b0, dc_on)
    pin(2, 1'b0);
    `CHK("standby off-only", 1'b0, dc_on)
    for (k = 0; k < 2; k++) begin
      wr(dcs_pkg::OFS_CFG, BASE | 32'h8 | (32'(k) << 2));
      pin(2, 1'(k));
      wr(dcs_pkg::OFS_CMD, C_ON);
      pin(2, 1'(~k));
      `CHK("standby active", 1'b0, dc_on)
      pin(2, 1'(k));
      `CHK("standby release", 1'b1, dc_on)
      wr(dcs_pkg::OFS_CMD, 32'h1 << dcs_pkg::CMD_OFF);
    end
    pin(2, 1'b0);
    recover(10, 3, 1'b1);
    recover(12, 0, 1'b0);
    rd(dcs_pkg::OFS_STATUS);
    // Leaving remote with the post-remote setting at off.
    wr(dcs_pkg::OFS_CFG, BASE);
    wr(dcs_pkg::OFS_CMD, C_IN | C_REM);
    wr(dcs_pkg::OFS_CMD, C_ON | C_REM);
    `CHK("remote on", 1'b1, dc_on)
    wr(dcs_pkg::OFS_CMD, C_EX);
    `CHK("after remote", 1'b0, dc_on)
    // Leaving remote with the post-remote setting at keep.
    wr(dcs_pkg::OFS_CFG, BASE | 32'h2000);
    wr(dcs_pkg::OFS_CMD, C_IN | C_REM);
    wr(dcs_pkg::OFS_CMD, C_ON | C_REM);
    wr(dcs_pkg::OFS_CMD, C_EX);
    `CHK("after remote kept", 1'b1, dc_on)
    wr(dcs_pkg::OFS_CMD, 32'h1 << dcs_pkg::CMD_OFF);
    // Permission cleared: remote ignored, local shown.
    wr(dcs_pkg::OFS_CFG, BASE & ~32'h1);
    `CHK("local only", 1'b1, local_only)
    wr(dcs_pkg::OFS_CMD, C_IN | C_REM);
    wr(dcs_pkg::OFS_CMD, C_ON | C_REM);
    rd(dcs_pkg::OFS_STATUS);
    `CHK("remote refused", 2'b10, rdata[4:3])
    `CHK("remote on refused", 1'b0, dc_on)
    // Switch-off: save, output off, fans, then full power-down.
    wr(dcs_pkg::OFS_CFG, BASE);
    wr(dcs_pkg::OFS_SETVAL, 32'h0000_a5c3);
    wr(dcs_pkg::OFS_CMD, C_ON);
    @(posedge clk);
    pins[1] <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (nv_store !== 1'b1 && k < 20);
    `CHK("store pulse", 1'b1, nv_store)
    `CHK("store on", 1'b1, nv_on)
    `CHK("store setval", 16'ha5c3, nv_setval)
    tick(1);
    `CHK("off at switch-off", 1'b0, dc_on)
    `CHK("fans still on", 1'b1, fan_on)
    tick(25);
    `CHK("fans off", 1'b0, fan_on)
    `CHK("still held", 1'b1, power_hold)
    tick(45);
    `CHK("powered down", 1'b0, power_hold)
    rd(dcs_pkg::OFS_STATUS);
    `CHK("pf at switch-off", 1'b1, rdata[1])
    // Power-up with restore off keeps the output off.
    @(posedge clk);
    srst    <= 1'b1;
    pins[1] <= 1'b0;
    tick(4);
    srst <= 1'b0;
    tick(3);
    `CHK("saved state", 1'b1, nv_restore_on)
    `CHK("power-up off", 1'b0, dc_on)
    tally_and_finish;
  end
endmodule : tb_top
